// file: ow_master_cfg.svh
// Timing and field constants for the single-wire bus master
`ifndef OW_MASTER_CFG_SVH
`define OW_MASTER_CFG_SVH

// ==========================================================
// Clock
// ==========================================================
`define CLK_MHZ           100

// ==========================================================
// Bus timing in microseconds
// ==========================================================
`define T_RSTL_US         480
`define T_RSTH_US         480
`define T_PDS_US          70
`define T_LOW1_US         2
`define T_LOW0_US         65
`define T_SLOT_US         70
`define T_RSMP_US         13
`define T_REC_US          2
`define T_PP_US           480
`define T_DP_US           5

// ==========================================================
// Cycle counts
// ==========================================================
`define CYC(us)           ((us) * `CLK_MHZ)

// ==========================================================
// Commands, fields and CRC
// ==========================================================
`define CMD_WR_OP         2'h0
`define CMD_RESET         2'h1
`define CMD_RD_OP         2'h2
`define CMD_PROG          2'h3
`define CRC_POLY          16'hA001
`define TAH_FORCE_BITS    8'hF8

`endif

// file: ow_master_pkg.sv
// Types shared by the single-wire bus master
package ow_master_pkg;

    typedef struct packed {
        logic [1:0] op;
        logic [7:0] data;
    } ow_cmd_t;

    typedef struct packed {
        logic       presence;
        logic [7:0] data;
    } ow_rsp_t;

    typedef struct packed {
        logic line_out;
        logic line_oe;
        logic prog_en;
    } ow_pins_t;

endpackage

// file: ow_master.sv
// Single-wire bus master with byte commands, program pulse and CRC-16 tracking
`include "ow_master_cfg.svh"

module ow_master #(
    parameter int RSTL_CYC = `CYC(`T_RSTL_US),
    parameter int RSTH_CYC = `CYC(`T_RSTH_US),
    parameter int PP_CYC   = `CYC(`T_PP_US),
    // Cycles per bus microsecond; lower it only to shorten simulation
    parameter int US_CYC   = `CLK_MHZ,
    parameter bit LOW_VPUP = 1'b0
) (
    input  wire logic                clock,
    input  wire logic                nrst,
    input  wire ow_master_pkg::ow_cmd_t cmd,
    input  wire logic                cmd_valid,
    input  wire logic                crc_clear,
    input  wire logic                crc_load,
    input  wire logic [15:0]         crc_load_val,
    input  wire logic                crc_ok_prog,
    input  wire logic                line_in,
    output logic                     cmd_ready,
    output ow_master_pkg::ow_rsp_t   rsp,
    output logic                     rsp_valid,
    output logic [15:0]              crc_r,
    output logic                     crc_match_r,
    output ow_master_pkg::ow_pins_t  pins
);
    import ow_master_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_RLOW, S_RHIGH, S_SLOT, S_REC, S_DP, S_PROG} state_t;

    localparam int LOW1_CYC  = `T_LOW1_US * US_CYC;
    localparam int LOW0_CYC  = `T_LOW0_US * US_CYC;
    localparam int SLOT_CYC  = `T_SLOT_US * US_CYC;
    localparam int RSMP_CYC  = `T_RSMP_US * US_CYC;
    localparam int REC_CYC   = `T_REC_US * US_CYC;
    localparam int PDS_CYC   = `T_PDS_US * US_CYC;
    localparam int DP_CYC    = `T_DP_US * US_CYC;

    // One LSB-first CRC-16 step, reflected form of x16+x15+x2+1
    function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
        logic fb;
        fb = c[0] ^ b;
        crc_bit = fb ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
    endfunction

    state_t      state_r;
    logic [31:0] cnt_r;
    logic [2:0]  bit_r;
    logic [7:0]  sh_r;
    logic        rd_r;
    logic        pres_r;
    logic        crc_en_r;
    logic        in_bit;

    // ==========================================================
    // Sequencer
    // ==========================================================
    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_r   <= S_IDLE;
            cnt_r     <= '0;
            bit_r     <= 3'h0;
            sh_r      <= 8'h00;
            rd_r      <= 1'b0;
            pres_r    <= 1'b0;
            crc_en_r  <= 1'b0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp       <= '0;
            pins      <= '0;
        end else begin
            rsp_valid <= 1'b0;
            cnt_r     <= cnt_r + 32'd1;
            unique case (state_r)
                S_IDLE: begin
                    cmd_ready <= 1'b1;
                    cnt_r     <= '0;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        unique case (cmd.op)
                            `CMD_RESET: begin
                                state_r      <= S_RLOW;
                                pins.line_oe <= 1'b1;
                            end
                            `CMD_PROG: begin
                                state_r <= crc_ok_prog ? S_DP : S_IDLE;
                                rsp_valid <= !crc_ok_prog;
                            end
                            default: begin
                                sh_r <= (LOW_VPUP && cmd.op == `CMD_WR_OP && cmd.data[7])
                                        ? (cmd.data | `TAH_FORCE_BITS) : cmd.data;
                                rd_r         <= (cmd.op == `CMD_RD_OP);
                                // Only written bytes feed the mirror; CRC read-back must not
                                crc_en_r     <= (cmd.op == `CMD_WR_OP);
                                bit_r        <= 3'h0;
                                state_r      <= S_SLOT;
                                pins.line_oe <= 1'b1;
                            end
                        endcase
                    end
                end
                S_RLOW: if (cnt_r == RSTL_CYC - 1) begin
                    pins.line_oe <= 1'b0;
                    pres_r       <= 1'b0;
                    cnt_r        <= '0;
                    state_r      <= S_RHIGH;
                end
                S_RHIGH: begin
                    if (cnt_r == PDS_CYC && !line_in)
                        pres_r <= 1'b1;
                    if (cnt_r == RSTH_CYC - 1) begin
                        rsp.presence <= pres_r;
                        rsp_valid    <= 1'b1;
                        state_r      <= S_IDLE;
                    end
                end
                S_SLOT: begin
                    if (cnt_r == ((rd_r || sh_r[0]) ? LOW1_CYC : LOW0_CYC) - 1)
                        pins.line_oe <= 1'b0;
                    if (cnt_r == RSMP_CYC - 1 && rd_r)
                        sh_r[0] <= line_in;
                    if (cnt_r == SLOT_CYC - 1) begin
                        cnt_r   <= '0;
                        state_r <= S_REC;
                    end
                end
                S_REC: if (cnt_r == REC_CYC - 1) begin
                    cnt_r <= '0;
                    sh_r  <= {sh_r[0], sh_r[7:1]};
                    bit_r <= bit_r + 3'h1;
                    if (bit_r == 3'h7) begin
                        rsp.data  <= {sh_r[0], sh_r[7:1]};
                        rsp_valid <= 1'b1;
                        crc_en_r  <= 1'b0;
                        state_r   <= S_IDLE;
                    end else begin
                        pins.line_oe <= 1'b1;
                        state_r      <= S_SLOT;
                    end
                end
                S_DP: if (cnt_r == DP_CYC - 1) begin
                    cnt_r        <= '0;
                    pins.prog_en <= 1'b1;
                    state_r      <= S_PROG;
                end
                S_PROG: begin
                    if (cnt_r == PP_CYC - 1) begin
                        pins.prog_en <= 1'b0;
                        rsp_valid    <= 1'b1;
                        state_r      <= S_IDLE;
                    end
                end
            endcase
        end
    end

    assign in_bit = sh_r[0];

    // ==========================================================
    // CRC mirror of the device generator
    // ==========================================================
    always_ff @(posedge clock) begin
        if (!nrst) begin
            crc_r <= 16'h0000;
        end else if (crc_clear) begin
            crc_r <= 16'h0000;
        end else if (crc_load) begin
            crc_r <= crc_load_val;
        end else if (crc_en_r && state_r == S_REC && cnt_r == REC_CYC - 1) begin
            crc_r <= crc_bit(crc_r, in_bit);
        end
    end

    // ==========================================================
    // Compare against the complemented CRC read back
    // ==========================================================
    logic [7:0] crc_lo_r;
    logic       crc_half_r;
    always_ff @(posedge clock) begin
        if (!nrst) begin
            crc_lo_r    <= 8'h00;
            crc_half_r  <= 1'b0;
            crc_match_r <= 1'b0;
        end else if (crc_clear || crc_load) begin
            crc_half_r <= 1'b0;
        end else if (rsp_valid && rd_r && !crc_en_r && state_r == S_IDLE) begin
            if (!crc_half_r) begin
                crc_lo_r   <= rsp.data;
                crc_half_r <= 1'b1;
            end else begin
                crc_half_r  <= 1'b0;
                crc_match_r <= ({rsp.data, crc_lo_r} == ~crc_r);
            end
        end
    end

endmodule // ow_master

// file: ow_master_asserts.sv
// Port checker for the single-wire bus master
`include "ow_master_cfg.svh"
module ow_master_asserts #(
    parameter int RSTL_CYC = 100,
    parameter int RSTH_CYC = 100,
    parameter int PP_CYC   = 100
) (
    input wire logic                    clock,
    input wire logic                    nrst,
    input wire ow_master_pkg::ow_cmd_t  cmd,
    input wire logic                    cmd_valid,
    input wire logic                    crc_ok_prog,
    input wire logic                    cmd_ready,
    input wire logic                    rsp_valid,
    input wire ow_master_pkg::ow_pins_t pins
);
    import ow_master_pkg::*;
    int   rst_cnt_r;
    int   pp_cnt_r;
    logic rst_ph_r;
    wire  take = cmd_valid && cmd_ready;
    // Reset phase runs from its take until its answer
    always_ff @(posedge clock) begin
        if (!nrst || rsp_valid)
            rst_ph_r <= 1'b0;
        else if (take && cmd.op == `CMD_RESET)
            rst_ph_r <= 1'b1;
    end
    always_ff @(posedge clock) begin
        rst_cnt_r <= (nrst && rst_ph_r) ? rst_cnt_r + 1 : 0;
    end
    always_ff @(posedge clock) begin
        pp_cnt_r <= (nrst && pins.prog_en) ? pp_cnt_r + 1 : 0;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    a_line_drain: assert property (pins.line_out == 1'b0)
        else $error("line_out driven high");
    a_prog_no_pull: assert property (pins.prog_en |-> !pins.line_oe)
        else $error("pull-down during program level");
    a_prog_refuse: assert property (take && cmd.op == `CMD_PROG && !crc_ok_prog
        |=> !pins.prog_en [*2])
        else $error("program level without crc approval");
    a_take_busy: assert property (take |=> !cmd_ready)
        else $error("ready right after a take");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer longer than one cycle");
    a_rst_low: assert property (rst_ph_r && $fell(pins.line_oe)
        |-> rst_cnt_r >= RSTL_CYC)
        else $error("reset low too short");
    a_rst_recover: assert property (rst_ph_r && rsp_valid
        |-> rst_cnt_r >= RSTL_CYC + RSTH_CYC - 1)
        else $error("reset recovery cut short");
    a_prog_width: assert property ($past(nrst) && $fell(pins.prog_en)
        |-> pp_cnt_r >= PP_CYC)
        else $error("program level too short");
endmodule // ow_master_asserts

bind ow_master ow_master_asserts #(
    .RSTL_CYC(RSTL_CYC), .RSTH_CYC(RSTH_CYC), .PP_CYC(PP_CYC)
) chk_u (.clock, .nrst, .cmd, .cmd_valid, .crc_ok_prog, .cmd_ready, .rsp_valid, .pins);

// file: ow_device_model.sv
// Behavioural model of the add-only memory on the bus
module ow_device_model #(
    parameter int US     = 1000,
    parameter int RST_NS = 75 * US,
    parameter int PDH_NS = 20 * US,
    parameter int PDL_NS = 65 * US
) (
    input  wire logic line,
    input  wire logic tx_en,
    output logic      pull
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] crc_r = 16'h0000;
    logic        bit_v;
    int          k = 0;
    int          nb = 0;
    time         t0;
    initial pull = 1'b0;
    always @(negedge line) begin
        t0 = $time;
        if (tx_en) begin
            bit_v = ~crc_r[k];
            k = k + 1;
            // valid within 1 us, zero held past 15 us
            #(US / 2) pull = ~bit_v;
            #(15 * US) pull = 1'b0;
        end else begin
            // Late sample so a short low reads as one
            #(30 * US) bit_v = line;
            wait (line);
            if ($time - t0 >= RST_NS) begin
                crc_r = 16'h0000;
                k = 0;
                nb = 0;
                #PDH_NS pull = 1'b1;
                #PDL_NS pull = 1'b0;
            end else begin
                // top five bits of the address-high byte forced to zero
                if (nb >= 19 && nb < 24)
                    bit_v = 1'b0;
                nb = nb + 1;
                crc_r = {1'b0, crc_r[15:1]} ^ ((crc_r[0] ^ bit_v) ? 16'hA001 : 16'h0000);
            end
        end
    end
endmodule // ow_device_model

// file: ow_master_test.sv
// Self-checking bench for the single-wire bus master
module ow_master_test;
    timeunit 1ns;
    timeprecision 100ps;
    import ow_master_pkg::*;
    localparam int PP = 100;
    logic clock, nrst, cmd_valid, crc_clear, crc_load, crc_ok_prog, line, tx_en, dev_pull;
    logic cmd_ready, rsp_valid, crc_match_r;
    logic [15:0] crc_load_val, crc_r, exp_crc;
    ow_cmd_t  cmd;
    ow_rsp_t  rsp;
    ow_pins_t pins;
    int n_fail = 0;
    int checks_done = 0;
    int pp;
    // Open-drain wire with pull-up
    assign line = !(pins.line_oe === 1'b1 || dev_pull === 1'b1);
    // Slot timing scaled tenfold down, reset and program lengths cut further, to keep the run short
    ow_master #(.RSTL_CYC(800), .RSTH_CYC(900), .PP_CYC(PP), .US_CYC(10)) dut_u (.clock, .nrst, .cmd,
        .cmd_valid, .crc_clear, .crc_load, .crc_load_val, .crc_ok_prog, .line_in(line),
        .cmd_ready, .rsp, .rsp_valid, .crc_r, .crc_match_r, .pins);
    ow_device_model #(.US(100)) dev_u (.line(line), .tx_en(tx_en), .pull(dev_pull));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        for (int i = 0; i < 8; i++) c = {1'b0, c[15:1]} ^ ((c[0] ^ d[i]) ? 16'hA001 : 16'h0);
        return c;
    endfunction
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until ready, then wait for the answer while counting program cycles
    task automatic run(input logic [1:0] op, input logic [7:0] d);
        pp = 0;
        @(posedge clock) #1 cmd = '{op: op, data: d};
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1) @(posedge clock) #1;
        @(posedge clock) #1 cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(posedge clock) #1 pp += (pins.prog_en === 1'b1);
    endtask
    task automatic pulse(input bit ld);
        @(posedge clock) #1 crc_load = ld;
        crc_clear = !ld;
        @(posedge clock) #1 {crc_load, crc_clear} = 2'h0;
    endtask
    task automatic t_reset;
        run(2'h1, 8'h00);
        cmp(16'(rsp.presence), 16'h0001);
        $display("reset done");
    endtask
    task automatic t_mirror;
        pulse(1'b1);
        cmp(crc_r, 16'h0013);
        pulse(1'b0);
        cmp(crc_r, 16'h0000);
        $display("mirror done");
    endtask
    task automatic t_write;
        exp_crc = crc_byte(16'h0000, 8'hA5);
        run(2'h0, 8'hA5);
        cmp(crc_r, exp_crc);
        $display("write done");
    endtask
    task automatic t_read;
        tx_en = 1'b1;
        run(2'h2, 8'h00);
        cmp({8'h00, rsp.data}, {8'h00, ~exp_crc[7:0]});
        run(2'h2, 8'h00);
        tx_en = 1'b0;
        cmp({8'h00, rsp.data}, {8'h00, ~exp_crc[15:8]});
        @(posedge clock) #1 cmp(crc_r, exp_crc);
        cmp(16'(crc_match_r), 16'h0001);
        $display("read done");
    endtask
    task automatic t_prog;
        crc_ok_prog = 1'b0;
        run(2'h3, 8'h00);
        cmp(16'(pp), 16'h0000);
        crc_ok_prog = 1'b1;
        run(2'h3, 8'h00);
        cmp(16'(pp), 16'(PP));
        $display("program done");
    endtask
    task automatic final_report;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        {nrst, cmd_valid, crc_clear, crc_load, crc_ok_prog, tx_en} = 6'h00;
        cmd = '0;
        crc_load_val = 16'h0013;
        repeat (5) @(posedge clock);
        #1 nrst = 1'b1;
        t_reset;
        t_mirror;
        t_write;
        t_read;
        t_prog;
        final_report;
    end
    // Run needs about 200 us of simulated time
    initial begin
        #400000 n_fail++;
        final_report;
    end
endmodule // ow_master_test
